// [pkg/uhc_pkg.sv]
package uhc_pkg;

    // Register byte addresses on the 9-bit register port
    localparam logic [8:0] ADDR_RESULT      = 9'h18E;
    localparam logic [8:0] ADDR_CFG_PRI     = 9'h190;
    localparam logic [8:0] ADDR_CFG_SEC     = 9'h191;
    localparam logic [8:0] ADDR_MPS_HI      = 9'h192;
    localparam logic [8:0] ADDR_MPS_LO      = 9'h193;
    localparam logic [8:0] ADDR_SIZE_HH     = 9'h194;
    localparam logic [8:0] ADDR_SIZE_HL     = 9'h195;
    localparam logic [8:0] ADDR_SIZE_LH     = 9'h196;
    localparam logic [8:0] ADDR_SIZE_LL     = 9'h197;
    localparam logic [8:0] ADDR_STATUS      = 9'h19C;
    localparam logic [8:0] ADDR_BO_CTL      = 9'h19D;

    // Field positions, primary configuration
    localparam int CFG_ACK_LSB   = 4;
    localparam int CFG_SPEED_LSB = 2;
    localparam int CFG_TOGGLE    = 1;
    localparam int CFG_GO        = 0;
    // Field positions, secondary configuration
    localparam int CFG_DIR_LSB   = 6;
    localparam int CFG_AUTO_ZL   = 3;
    localparam int CFG_UNLIM     = 0;
    // Field positions, result code and status
    localparam int RES_CODE_LSB  = 4;
    localparam int ST_ACK_REACH  = 0;
    localparam int ST_SIZE_DONE  = 1;
    localparam int ST_COND_CHG   = 2;
    localparam int BO_GO         = 0;

    // Reset values
    localparam logic [7:0]  CFG_PRI_RST = 8'h00;
    localparam logic [7:0]  CFG_SEC_RST = 8'h00;
    localparam logic [9:0]  MPS_RST     = 10'h000;
    localparam logic [31:0] SIZE_RST    = 32'h0000_0000;
    localparam logic [3:0]  ACK_FULL    = 4'h0;    // Zero selects sixteen
    localparam logic [4:0]  ACK_SIXTEEN = 5'h10;

    // Encodings
    localparam logic [1:0] SPEED_HS = 2'h0;
    localparam logic [1:0] SPEED_FS = 2'h1;
    localparam logic [1:0] DIR_OUT  = 2'h1;
    localparam logic [1:0] DIR_IN   = 2'h2;

    typedef enum logic [2:0] {
        RC_NO_ERROR = 3'h0,
        RC_STALL    = 3'h1,
        RC_OVERRUN  = 3'h2,
        RC_UNDERRUN = 3'h3,
        RC_RETRY    = 3'h4
    } uhc_code_t;

    // Transaction request toward the packet engine
    typedef struct packed {
        logic [1:0] dir;
        logic [1:0] speed;
        logic       toggle;
        logic [9:0] length;
    } uhc_req_t;

    // Transaction outcome from the packet engine
    typedef struct packed {
        logic [2:0]  code;
        logic        acked;
        logic        toggle;
        logic [9:0]  nbytes;
    } uhc_res_t;

endpackage

// [src/uhc_ack_counter.sv]
`timescale 1ns/1ps
// Counts handshakes and pulses once the programmed number is reached
module uhc_ack_counter #(
    parameter int CNT_W = 5
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       clear_i,
    input  wire logic       ack_i,
    input  wire logic [3:0] limit_i,
    // Result
    output logic            reached_o
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] target;

    // Zero in the field stands for sixteen
    always_comb begin
        count_nxt = count_r + 1'b1;
        target    = (limit_i == uhc_pkg::ACK_FULL) ? uhc_pkg::ACK_SIXTEEN
                                                   : {1'b0, limit_i};
    end

    // Wraps to zero so the next group counts afresh
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r   <= '0;
            reached_o <= 1'b0;
        end else if (clear_i) begin
            count_r   <= '0;
            reached_o <= 1'b0;
        end else if (ack_i && count_nxt == target) begin
            count_r   <= '0;
            reached_o <= 1'b1;
        end else begin
            count_r   <= ack_i ? count_nxt : count_r;
            reached_o <= 1'b0;
        end
    end

endmodule // uhc_ack_counter

// [src/uhc_channel.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Contract
// - ACK count field; zero means sixteen
// - Count reached sets handshake status flag
// - Bulk-only mode counts data transactions only
// - Speed field 00 high, 01 full
// - Toggle seeds transaction, reads current state
// - Go starts, zero stops, reads running
// - Byte count done sets flag, clears go
// - Condition change clears go, records result
// - Stop finishes current transaction, then flags
// - Stop keeps count and settings for resume
// - Direction 01 issues OUT, 10 IN
// - Bulk-only go overrides direction field
// - Auto zero-length after exact OUT boundary
// - Unlimited bit ignores total size
// - Ten-bit max packet, upper bits reserved
// - Result codes: none, stall, overrun, underrun, retry
// - Remaining count drops per good transaction
module uhc_channel (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    // Register port
    input  wire logic [8:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // Packet engine request
    output logic                  xact_req_o,
    output uhc_pkg::uhc_req_t     xact_o,
    // Packet engine outcome
    input  wire logic             xact_done_i,
    input  wire uhc_pkg::uhc_res_t xact_res_i,
    // Bulk-only sequencer
    input  wire logic [1:0]       bo_dir_i,
    input  wire logic             bo_data_phase_i,
    // Channel state
    output logic                  running_o,
    output logic      [2:0]       status_o
);

    typedef enum logic {
        UHC_IDLE,
        UHC_BUSY
    } uhc_state_t;

    // Reset release synchroniser
    logic        rst_meta_r;
    logic        rst_n_r;

    // Registers
    logic [3:0]  ack_limit_r;
    logic [1:0]  speed_r;
    logic        toggle_r;
    logic        go_r;
    logic [1:0]  dir_r;
    logic        auto_zl_r;
    logic        unlim_r;
    logic [9:0]  mps_r;
    logic [31:0] remain_r;
    logic [2:0]  code_r;
    logic        flag_ack_r;
    logic        flag_size_r;
    logic        flag_cc_r;
    logic        bo_go_r;
    logic        stop_req_r;
    logic        zlp_pend_r;
    uhc_state_t  state_r;
    logic [9:0]  len_r;

    // Decoded accesses and events
    logic        wr_pri;
    logic        wr_sec;
    logic        wr_status;
    logic        go_write_one;
    logic        go_write_zero;
    logic [1:0]  dir_eff;
    logic        done_ok;
    logic        done_err;
    logic [31:0] remain_after;
    logic        last_pkt;
    logic        need_zlp;
    logic        finish_ok;
    logic        idle_done;
    logic        launch;
    logic        stop_done;
    logic        idle_stop;
    logic        ack_event;
    logic        ack_reached;
    logic [9:0]  launch_len;
    logic [7:0]  rdata_nxt;

    // Async assert, two-flop synchronous release
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Write decode
    assign wr_pri        = wr_i && addr_i == uhc_pkg::ADDR_CFG_PRI;
    assign wr_sec        = wr_i && addr_i == uhc_pkg::ADDR_CFG_SEC;
    assign wr_status     = wr_i && addr_i == uhc_pkg::ADDR_STATUS;
    assign go_write_one  = wr_pri && wdata_i[uhc_pkg::CFG_GO];
    assign go_write_zero = wr_pri && !wdata_i[uhc_pkg::CFG_GO];

    // Sequencer direction wins once bulk-only runs
    assign dir_eff = bo_go_r ? bo_dir_i : dir_r;

    // Transaction outcome decode
    always_comb begin
        done_ok      = state_r == UHC_BUSY && xact_done_i
                       && xact_res_i.code == uhc_pkg::RC_NO_ERROR;
        done_err     = state_r == UHC_BUSY && xact_done_i
                       && xact_res_i.code != uhc_pkg::RC_NO_ERROR;
        // Saturate so an over-long packet cannot wrap the count
        remain_after = (remain_r > {22'h0, xact_res_i.nbytes})
                       ? remain_r - {22'h0, xact_res_i.nbytes} : 32'h0000_0000;
        last_pkt     = !unlim_r && remain_after == 32'h0000_0000;
        need_zlp     = last_pkt && auto_zl_r && dir_eff == uhc_pkg::DIR_OUT
                       && len_r == mps_r && !zlp_pend_r;
        finish_ok    = done_ok && (zlp_pend_r || (last_pkt && !need_zlp));
        // A stop written in the done cycle still ends from idle
        stop_done    = stop_req_r && ((state_r == UHC_BUSY && xact_done_i && !finish_ok && !done_err)
                       || (state_r == UHC_IDLE && go_r && !go_write_one));
        // IN with nothing left finishes at once; OUT sends one empty packet
        idle_done    = state_r == UHC_IDLE && go_r && !stop_req_r && !unlim_r
                       && !zlp_pend_r && remain_r == 32'h0000_0000
                       && dir_eff == uhc_pkg::DIR_IN;
        launch       = state_r == UHC_IDLE && go_r && !stop_req_r && !idle_done;
        idle_stop    = state_r == UHC_IDLE && go_r && go_write_zero;
        ack_event    = done_ok && xact_res_i.acked
                       && (!bo_go_r || bo_data_phase_i);
    end

    // Packet length: full packets until the tail
    always_comb begin
        if (zlp_pend_r) begin
            launch_len = 10'h000;
        end else if (unlim_r || remain_r >= {22'h0, mps_r}) begin
            launch_len = mps_r;
        end else begin
            launch_len = remain_r[9:0];
        end
    end

    // Primary configuration fields
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ack_limit_r <= uhc_pkg::CFG_PRI_RST[7:4];
            speed_r     <= uhc_pkg::CFG_PRI_RST[3:2];
        end else if (wr_pri) begin
            ack_limit_r <= wdata_i[uhc_pkg::CFG_ACK_LSB +: 4];
            speed_r     <= wdata_i[uhc_pkg::CFG_SPEED_LSB +: 2];
        end
    end

    // Toggle: seeded by software, tracked by good transactions
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            toggle_r <= 1'b0;
        end else if (done_ok) begin
            toggle_r <= xact_res_i.toggle;
        end else if (wr_pri && state_r == UHC_IDLE) begin
            toggle_r <= wdata_i[uhc_pkg::CFG_TOGGLE];
        end
    end

    // Go bit: software start wins over a same-cycle hardware clear
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            go_r <= 1'b0;
        end else if (go_write_one) begin
            go_r <= 1'b1;
        end else if (finish_ok || idle_done || done_err || stop_done || idle_stop) begin
            go_r <= 1'b0;
        end
    end

    // Stop request waits for the transaction on the wire
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stop_req_r <= 1'b0;
        end else if (go_write_one || !go_r) begin
            stop_req_r <= 1'b0;
        end else if (go_write_zero) begin
            stop_req_r <= 1'b1;
        end
    end

    // Secondary configuration; reserved bits are not stored
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dir_r     <= uhc_pkg::CFG_SEC_RST[7:6];
            auto_zl_r <= uhc_pkg::CFG_SEC_RST[3];
            unlim_r   <= uhc_pkg::CFG_SEC_RST[0];
        end else if (wr_sec) begin
            dir_r     <= wdata_i[uhc_pkg::CFG_DIR_LSB +: 2];
            auto_zl_r <= wdata_i[uhc_pkg::CFG_AUTO_ZL];
            unlim_r   <= wdata_i[uhc_pkg::CFG_UNLIM];
        end
    end

    // Max packet size, upper six bits dropped
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mps_r <= uhc_pkg::MPS_RST;
        end else if (wr_i && addr_i == uhc_pkg::ADDR_MPS_HI) begin
            mps_r <= {wdata_i[1:0], mps_r[7:0]};
        end else if (wr_i && addr_i == uhc_pkg::ADDR_MPS_LO) begin
            mps_r <= {mps_r[9:8], wdata_i};
        end
    end

    // Remaining byte count survives a stop so go can resume
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            remain_r <= uhc_pkg::SIZE_RST;
        end else if (done_ok && !unlim_r) begin
            remain_r <= remain_after;
        end else if (wr_i && addr_i == uhc_pkg::ADDR_SIZE_HH) begin
            remain_r <= {wdata_i, remain_r[23:0]};
        end else if (wr_i && addr_i == uhc_pkg::ADDR_SIZE_HL) begin
            remain_r <= {remain_r[31:24], wdata_i, remain_r[15:0]};
        end else if (wr_i && addr_i == uhc_pkg::ADDR_SIZE_LH) begin
            remain_r <= {remain_r[31:16], wdata_i, remain_r[7:0]};
        end else if (wr_i && addr_i == uhc_pkg::ADDR_SIZE_LL) begin
            remain_r <= {remain_r[31:8], wdata_i};
        end
    end

    // Result code of the last channel stop
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            code_r <= uhc_pkg::RC_NO_ERROR;
        end else if (done_err) begin
            code_r <= xact_res_i.code;
        end else if (stop_done || idle_stop || finish_ok || idle_done) begin
            code_r <= uhc_pkg::RC_NO_ERROR;
        end
    end

    // Sticky status: write one clears, a new event wins
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flag_ack_r  <= 1'b0;
            flag_size_r <= 1'b0;
            flag_cc_r   <= 1'b0;
        end else begin
            flag_ack_r  <= ack_reached
                           || (flag_ack_r && !(wr_status && wdata_i[uhc_pkg::ST_ACK_REACH]));
            flag_size_r <= (finish_ok || idle_done)
                           || (flag_size_r && !(wr_status && wdata_i[uhc_pkg::ST_SIZE_DONE]));
            flag_cc_r   <= (done_err || stop_done || idle_stop)
                           || (flag_cc_r && !(wr_status && wdata_i[uhc_pkg::ST_COND_CHG]));
        end
    end

    // Bulk-only sequencer enable
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bo_go_r <= 1'b0;
        end else if (wr_i && addr_i == uhc_pkg::ADDR_BO_CTL) begin
            bo_go_r <= wdata_i[uhc_pkg::BO_GO];
        end
    end

    // Channel engine: one transaction at a time
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r    <= UHC_IDLE;
            xact_req_o <= 1'b0;
            len_r      <= 10'h000;
            zlp_pend_r <= 1'b0;
        end else begin
            xact_req_o <= 1'b0;
            case (state_r)
                UHC_IDLE: begin
                    if (launch) begin
                        state_r    <= UHC_BUSY;
                        xact_req_o <= 1'b1;
                        len_r      <= launch_len;
                    end
                end
                UHC_BUSY: begin
                    if (xact_done_i) begin
                        state_r <= UHC_IDLE;
                    end
                    if (need_zlp && done_ok) begin
                        zlp_pend_r <= 1'b1;
                    end else if (done_ok || done_err) begin
                        zlp_pend_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= UHC_IDLE;
                end
            endcase
        end
    end

    // Request fields held beside the strobe
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            xact_o <= '0;
        end else if (launch) begin
            xact_o.dir    <= dir_eff;
            xact_o.speed  <= speed_r;
            xact_o.toggle <= toggle_r;
            xact_o.length <= launch_len;
        end
    end

    // Handshake counter restarts with each go written while stopped
    uhc_ack_counter #(
        .CNT_W (5)
    ) u_ack_counter (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_r),
        .clear_i   (go_write_one && !go_r),
        .ack_i     (ack_event),
        .limit_i   (ack_limit_r),
        .reached_o (ack_reached)
    );

    // Read mux; unmapped and reserved bits read zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (addr_i)
            uhc_pkg::ADDR_RESULT:  rdata_nxt[uhc_pkg::RES_CODE_LSB +: 3] = code_r;
            uhc_pkg::ADDR_CFG_PRI: rdata_nxt = {ack_limit_r, speed_r, toggle_r, go_r};
            uhc_pkg::ADDR_CFG_SEC: rdata_nxt = {dir_r, 2'h0, auto_zl_r, 2'h0, unlim_r};
            uhc_pkg::ADDR_MPS_HI:  rdata_nxt = {6'h00, mps_r[9:8]};
            uhc_pkg::ADDR_MPS_LO:  rdata_nxt = mps_r[7:0];
            uhc_pkg::ADDR_SIZE_HH: rdata_nxt = remain_r[31:24];
            uhc_pkg::ADDR_SIZE_HL: rdata_nxt = remain_r[23:16];
            uhc_pkg::ADDR_SIZE_LH: rdata_nxt = remain_r[15:8];
            uhc_pkg::ADDR_SIZE_LL: rdata_nxt = remain_r[7:0];
            uhc_pkg::ADDR_STATUS:  rdata_nxt = {5'h00, flag_cc_r, flag_size_r, flag_ack_r};
            uhc_pkg::ADDR_BO_CTL:  rdata_nxt = {7'h00, bo_go_r};
            default:               rdata_nxt = 8'h00;
        endcase
    end

    // Read data valid only the cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rdata_nxt : 8'h00;
        end
    end

    // Mirrored state outputs
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            running_o <= 1'b0;
            status_o  <= 3'h0;
        end else begin
            running_o <= go_r;
            status_o  <= {flag_cc_r, flag_size_r, flag_ack_r};
        end
    end

endmodule // uhc_channel

// [tb/uhc_checker.sv]
`timescale 1ns/1ps
// Port-level properties of the host channel block
module uhc_checker (
    // Clock and reset
    input wire logic              clock_i,
    input wire logic              resetn_i,
    // Register port
    input wire logic [8:0]        addr_i,
    input wire logic [7:0]        wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [7:0]        rdata_o,
    // Engine side and channel state
    input wire logic              xact_req_o,
    input wire uhc_pkg::uhc_req_t xact_o,
    input wire logic              xact_done_i,
    input wire uhc_pkg::uhc_res_t xact_res_i,
    input wire logic [1:0]        bo_dir_i,
    input wire logic              bo_data_phase_i,
    input wire logic              running_o,
    input wire logic [2:0]        status_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic go_wr;
    logic good_ack;
    // Start from idle, and a clean acknowledged outcome
    assign go_wr = wr_i && addr_i == uhc_pkg::ADDR_CFG_PRI && wdata_i[0] && !running_o;
    assign good_ack = xact_done_i && xact_res_i.acked && xact_res_i.code == 3'h0;

    go_start_a: assert property (go_wr |-> ##[1:4] xact_req_o) else $error("no request after start");
    go_run_a: assert property (go_wr |-> ##2 running_o) else $error("running not shown");
    done_gap_a: assert property (xact_done_i |=> !xact_req_o) else $error("request too soon");
    xact_hold_a: assert property (!xact_req_o |-> $stable(xact_o)) else $error("request moved");
    size_done_a: assert property ($rose(status_o[uhc_pkg::ST_SIZE_DONE]) |->
        ($past(xact_done_i, 2) || $past(wr_i, 3)) ##1 !running_o) else $error("size flag wrong");
    cond_chg_a: assert property ($rose(status_o[uhc_pkg::ST_COND_CHG]) |->
        ($past(xact_done_i, 2) || $past(xact_done_i, 3) || $past(wr_i, 2) || $past(wr_i, 3))
        ##1 !running_o) else $error("change flag wrong");
    ack_reach_a: assert property ($rose(status_o[uhc_pkg::ST_ACK_REACH]) |-> $past(good_ack, 3))
        else $error("ack flag without ack");
    rsv_sec_a: assert property (rd_i && addr_i == uhc_pkg::ADDR_CFG_SEC |=> (rdata_o & 8'h36) == 8'h00)
        else $error("reserved bits set");
    rsv_mps_a: assert property (rd_i && addr_i == uhc_pkg::ADDR_MPS_HI |=> rdata_o[7:2] == 6'h00)
        else $error("packet size upper bits set");
    idle_read_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not cleared");
    // Main scenarios
    cover property (xact_done_i && xact_res_i.code != 3'h0);
    cover property ($rose(status_o[uhc_pkg::ST_COND_CHG]));
    cover property ($rose(status_o[uhc_pkg::ST_ACK_REACH]));
endmodule // uhc_checker

bind uhc_channel uhc_checker u_chk (.clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .xact_req_o, .xact_o, .xact_done_i, .xact_res_i, .bo_dir_i, .bo_data_phase_i, .running_o, .status_o);

// [tb/uhc_engine_model.sv]
`timescale 1ns/1ps
// Packet engine stand-in: one outstanding request, answered after a wait
module uhc_engine_model (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    // Request from the channel
    input  wire logic              xact_req_i,
    input  wire uhc_pkg::uhc_req_t xact_i,
    // Outcome chosen by the bench
    input  wire logic [2:0]        code_i,
    input  wire logic [1:0]        delay_i,
    // Outcome to the channel
    output logic                   done_o,
    output uhc_pkg::uhc_res_t      res_o
);
    uhc_pkg::uhc_req_t held;
    // Outcome is valid only in the done cycle; scrambled elsewhere
    initial begin
        done_o = 1'b0;
        res_o = '0;
        forever begin
            @(posedge clock_i);
            if (resetn_i && xact_req_i) begin
                held = xact_i;
                repeat (delay_i) @(posedge clock_i);
                done_o <= 1'b1;
                res_o <= {code_i, code_i == 3'h0, held.toggle ^ (code_i == 3'h0), held.length};
                @(posedge clock_i);
                done_o <= 1'b0;
                res_o <= ~res_o;
            end
        end
    end
endmodule // uhc_engine_model

// [tb/uhc_channel_tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench for the host channel block
module uhc_channel_tb_top;
    logic              clock_i = 1'b0;
    logic              resetn_i = 1'b0;
    logic [8:0]        addr_i = '0;
    logic [7:0]        wdata_i = '0;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [1:0]        bo_dir_i = 2'h0;
    logic              bo_data_phase_i = 1'b0;
    logic [2:0]        code = 3'h0;
    logic [1:0]        delay = 2'h1;
    logic [7:0]        rdata_o;
    logic              xact_req_o;
    logic              running_o;
    logic [2:0]        status_o;
    logic              xact_done_i;
    uhc_pkg::uhc_req_t xact_o;
    uhc_pkg::uhc_res_t xact_res_i;
    logic [15:0]       rd_q[$];
    logic [15:0]       x_q[$];
    logic              rd_seen = 1'b0;
    int                bad_count = 0;
    int                num_checks = 0;
    int                seed = 53340;
    int                nreq = 0;

    uhc_channel uut (.clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .xact_req_o, .xact_o,
        .xact_done_i, .xact_res_i, .bo_dir_i, .bo_data_phase_i, .running_o, .status_o);
    uhc_engine_model eng (.clock_i, .resetn_i, .xact_req_i(xact_req_o), .xact_i(xact_o), .code_i(code),
        .delay_i(delay), .done_o(xact_done_i), .res_o(xact_res_i));

    always #4 clock_i = ~clock_i;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // One-cycle strobes with a gap, so no signal is set twice at one edge
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        rd_q.push_back({8'h00, e});
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic ex(input logic [1:0] d, input logic [1:0] s, input logic t, input logic [9:0] n);
        x_q.push_back({1'b0, d, s, t, n});
    endtask
    // Clear flags, program secondary word, packet size and byte count
    task automatic setup(input logic [7:0] sec, input logic [9:0] mps, input logic [31:0] sz);
        wr(uhc_pkg::ADDR_STATUS, 8'h07);
        wr(uhc_pkg::ADDR_CFG_SEC, sec);
        wr(uhc_pkg::ADDR_MPS_HI, {6'h00, mps[9:8]});
        wr(uhc_pkg::ADDR_MPS_LO, mps[7:0]);
        for (int i = 0; i < 4; i++)
            wr(uhc_pkg::ADDR_SIZE_HH + 9'(i), sz[31 - 8 * i -: 8]);
        delay <= 2'($random(seed));
    endtask
    // Bounded wait for the channel to stop
    task automatic run(input logic [7:0] pri);
        wr(uhc_pkg::ADDR_CFG_PRI, pri);
        repeat (3) @(posedge clock_i);
        for (int i = 0; i < 400 && running_o !== 1'b0; i++)
            @(posedge clock_i);
        if (running_o !== 1'b0)
            bad_count++;
        repeat (2) @(posedge clock_i);
    endtask

    // Read data and requests compared with the oldest note
    always @(posedge clock_i) begin
        if (rd_seen)
            check({8'h00, rdata_o}, rd_q.pop_front());
        if (xact_req_o === 1'b1) begin
            nreq++;
            check({1'b0, xact_o}, x_q.pop_front());
        end
        rd_seen <= rd_i;
    end

    initial begin
        #(8 * 30000);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        // Every register resets to zero; unmapped places read zero
        for (int a = 9'h18E; a <= 9'h1A0; a++)
            rd(9'(a), 8'h00);
        wr(uhc_pkg::ADDR_RESULT, 8'hFF);
        rd(uhc_pkg::ADDR_RESULT, 8'h00);
        wr(uhc_pkg::ADDR_CFG_SEC, 8'hBF);
        rd(uhc_pkg::ADDR_CFG_SEC, 8'h89);
        wr(uhc_pkg::ADDR_MPS_HI, 8'h03);
        rd(uhc_pkg::ADDR_MPS_HI, 8'h03);
        // Full-speed OUT of 130 bytes, three acks to count
        setup(8'h40, 10'h040, 32'd130);
        ex(2'h1, 2'h1, 1'b0, 10'd64);
        ex(2'h1, 2'h1, 1'b1, 10'd64);
        ex(2'h1, 2'h1, 1'b0, 10'd2);
        run(8'h35);
        rd(uhc_pkg::ADDR_STATUS, 8'h03);
        rd(uhc_pkg::ADDR_CFG_PRI, 8'h36);
        // High-speed OUT on an exact boundary gets one empty packet
        setup(8'h48, 10'h200, 32'd1024);
        ex(2'h1, 2'h0, 1'b1, 10'd512);
        ex(2'h1, 2'h0, 1'b0, 10'd512);
        ex(2'h1, 2'h0, 1'b1, 10'd0);
        run(8'h03);
        rd(uhc_pkg::ADDR_STATUS, 8'h02);
        rd(uhc_pkg::ADDR_CFG_PRI, 8'h00);
        // Unlimited IN: sixteen packets, stopped while the last is in flight
        setup(8'h81, 10'h008, 32'd3);
        delay <= 2'h3;
        for (int i = 0; i < 16; i++)
            ex(2'h2, 2'h1, i[0], 10'd8);
        nreq = 0;
        wr(uhc_pkg::ADDR_CFG_PRI, 8'h05);
        for (int i = 0; i < 600 && nreq < 16; i++)
            @(posedge clock_i);
        if (nreq < 16)
            bad_count++;
        rd(uhc_pkg::ADDR_STATUS, 8'h00);
        run(8'h04);
        rd(uhc_pkg::ADDR_STATUS, 8'h05);
        rd(uhc_pkg::ADDR_RESULT, 8'h00);
        // Each error code stops the channel; the count survives for resume
        setup(8'h40, 10'h040, 32'd10);
        for (int c = 1; c <= 5; c++) begin
            code <= 3'(c % 5);
            ex(2'h1, 2'h1, 1'b0, 10'd10);
            run(8'h15);
            rd(uhc_pkg::ADDR_STATUS, (c == 5) ? 8'h03 : 8'h04);
            rd(uhc_pkg::ADDR_RESULT, {1'b0, 3'(c % 5), 4'h0});
            wr(uhc_pkg::ADDR_STATUS, 8'h07);
        end
        // Sequencer direction wins; acks count only in the data phase
        wr(uhc_pkg::ADDR_BO_CTL, 8'h01);
        bo_dir_i <= 2'h2;
        for (int p = 0; p < 2; p++) begin
            bo_data_phase_i <= p[0];
            setup(8'h40, 10'h020, 32'd5);
            ex(2'h2, 2'h1, 1'b0, 10'd5);
            run(8'h15);
            rd(uhc_pkg::ADDR_STATUS, {7'h01, p[0]});
        end
        // Every noted request and read must have been seen
        repeat (2) @(posedge clock_i);
        check(16'(x_q.size() + rd_q.size()), 16'h0000);
        final_report();
    end
endmodule // uhc_channel_tb_top
